// *** common/scan_tap_pkg.sv ***
package scan_tap_pkg;

  // ------------------------------------------------------------
  // widths
  // ------------------------------------------------------------
  localparam int CELL_W = 8;               // cells per side of the chain
  localparam int CHAIN_W = 16;             // output cells [15:8], input cells [7:0]
  localparam int BCR_W = 11;               // opcode [2:0], masks [10:3]
  localparam int IR_W = 8;
  localparam int SYNC_W = 13;              // tck, tms, tdi, le, oe_n, data[7:0]

  // ------------------------------------------------------------
  // instruction codes
  // ------------------------------------------------------------
  localparam logic [7:0] IR_CAPTURE = 8'h81;   // fixed capture pattern 10000001
  localparam logic [7:0] IR_BYPASS = 8'hFF;
  localparam logic [7:0] IR_RUN_TEST = 8'h0A;  // run_test_instruction
  localparam logic [7:0] IR_BCR_SCAN = 8'h0E;  // boundary_control_register in path
  localparam logic [7:0] IR_CHAIN_SCAN = 8'h82; // boundary_chain in path

  // ------------------------------------------------------------
  // run-test opcodes and feedback
  // ------------------------------------------------------------
  localparam logic [2:0] OP_SIG_RANDOM = 3'h3; // signature_plus_random
  localparam logic [2:0] OP_SIG_COUNT = 3'h7;  // signature_plus_count
  localparam int BCR_OP_LSB = 0;
  localparam int BCR_MASK_LSB = 3;
  localparam logic [7:0] LFSR_TAPS = 8'hB8;    // x^8+x^6+x^5+x^4+1, maximal length

  // ------------------------------------------------------------
  // apb register map
  // ------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_SIGN = 12'h008;
  localparam logic CTRL_RESET = 1'b1;          // port enabled after reset
  localparam int ST_STATE_LSB = 0;
  localparam int ST_INSTR_LSB = 8;
  localparam int ST_TEST_BIT = 16;
  localparam int SG_IN_LSB = 0;
  localparam int SG_OUT_LSB = 8;
  localparam int SG_BCR_LSB = 16;

  // ------------------------------------------------------------
  // tap states, gray along the usual walk
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_RESET = 4'h0, ST_IDLE = 4'h1, ST_SEL_DR = 4'h3, ST_CAP_DR = 4'h2,
    ST_SH_DR = 4'h6, ST_EX1_DR = 4'h7, ST_PAU_DR = 4'h5, ST_EX2_DR = 4'h4,
    ST_UPD_DR = 4'hC, ST_SEL_IR = 4'hD, ST_CAP_IR = 4'hF, ST_SH_IR = 4'hE,
    ST_EX1_IR = 4'hA, ST_PAU_IR = 4'hB, ST_EX2_IR = 4'h9, ST_UPD_IR = 4'h8
  } tap_state_t;

  // synchronised pin bundle with tck edges
  typedef struct packed {
    logic tck_rise;
    logic tck_fall;
    logic tms;
    logic tdi;
    logic le;
    logic oe_n;
    logic [7:0] data;
  } pin_sync_t;

endpackage : scan_tap_pkg

// *** design/pin_sync.sv ***
`timescale 1ns/10ps
`default_nettype none
module pin_sync
  import scan_tap_pkg::*;
#(
  parameter int W = SYNC_W
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // raw pins, bit 0 is tck
  input wire logic [W-1:0] raw,
  // synchronised levels and tck edges
  output logic [W-1:0] sync,
  output logic rise,
  output logic fall
);

  // ------------------------------------------------------------
  // two-stage synchroniser per bit
  // ------------------------------------------------------------
  logic [W-1:0] meta_q; // first stage, read only by the second
  logic tck_old_q;      // tck one clock later for edge finding

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      // each pin gets its own pair of flops
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_q[i] <= 1'b0;
          sync[i] <= 1'b0;
        end else begin
          meta_q[i] <= raw[i];
          sync[i] <= meta_q[i];
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // tck edge detect on the second stage only
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tck_old_q <= 1'b0;
    end else begin
      tck_old_q <= sync[0];
    end
  end

  assign rise = sync[0] & ~tck_old_q;
  assign fall = ~sync[0] & tck_old_q;

endmodule : pin_sync
`default_nettype wire

// *** design/scan_signature_pattern_tap.sv ***
`timescale 1ns/10ps
`default_nettype none
module scan_signature_pattern_tap
  import scan_tap_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // test access port pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  // latch function pins
  input wire logic [7:0] data_in,
  input wire logic latch_enable,
  input wire logic output_enable_n,
  output logic [7:0] data_out,
  output logic data_out_oe
);

  // ------------------------------------------------------------
  // pin synchronisation
  // ------------------------------------------------------------
  logic [SYNC_W-1:0] sync_w;  // synchronised pin levels
  logic rise_w;               // tck rising edge seen
  logic fall_w;               // tck falling edge seen
  pin_sync_t pin;             // bundle used by the tap logic

  pin_sync #(.W(SYNC_W)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .raw({data_in, output_enable_n, latch_enable, tdi, tms, tck}),
    .sync(sync_w),
    .rise(rise_w),
    .fall(fall_w)
  );

  // tms and tdi pass the same two stages as tck, so at the seen
  // rising edge they hold the level present at the real edge
  assign pin.tck_rise = rise_w;
  assign pin.tck_fall = fall_w;
  assign pin.tms = sync_w[1];
  assign pin.tdi = sync_w[2];
  assign pin.le = sync_w[3];
  assign pin.oe_n = sync_w[4];
  assign pin.data = sync_w[12:5];

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  tap_state_t state_q, state_d;       // tap controller
  logic [IR_W-1:0] ir_sh_q;           // instruction_shift_register
  logic [IR_W-1:0] ir_act_q;          // active instruction
  logic bypass_q;                     // single bypass stage
  logic [BCR_W-1:0] bcr_sh_q;         // control register shift stage
  logic [BCR_W-1:0] bcr_q;            // control register holding stage
  logic [CHAIN_W-1:0] chain_q;        // boundary_chain shift stages
  logic [CHAIN_W-1:0] shadow_q;       // boundary_cell shadow latches
  logic [7:0] core_q;                 // normal latch core
  logic tdo_q, tdo_oe_q;              // tdo pin registers
  logic [7:0] dout_q;                 // output pin register
  logic dout_oe_q;                    // output pin enable register
  logic ctrl_en_q;                    // software enable of the port
  logic [31:0] prdata_q;              // apb read data
  logic pready_q;                     // apb wait-state flag
  logic pslverr_q;                    // apb error flag

  // ------------------------------------------------------------
  // instruction and mode decode
  // ------------------------------------------------------------
  wire sel_bcr = (ir_act_q == IR_BCR_SCAN);
  wire sel_chain = (ir_act_q == IR_CHAIN_SCAN);
  wire test_mode = (ir_act_q == IR_RUN_TEST);
  wire [2:0] opcode = bcr_q[BCR_OP_LSB +: 3];
  wire [7:0] in_mask = bcr_q[BCR_MASK_LSB +: 8];
  wire run_sig_rand = test_mode && (state_q == ST_IDLE) && (opcode == OP_SIG_RANDOM);
  wire run_sig_cnt = test_mode && (state_q == ST_IDLE) && (opcode == OP_SIG_COUNT);
  wire run_any = run_sig_rand || run_sig_cnt;

  // ------------------------------------------------------------
  // signature and pattern feedback
  // ------------------------------------------------------------
  wire [7:0] in_cells = chain_q[7:0];
  wire [7:0] out_cells = chain_q[15:8];
  wire sig_fb = ^(in_cells & LFSR_TAPS);
  wire [7:0] sig_next = {in_cells[6:0], sig_fb} ^ (pin.data & ~in_mask);
  wire rnd_fb = ^(out_cells & LFSR_TAPS);
  // an all-zero seed keeps rnd_fb at zero, so the pattern stays stuck
  wire [7:0] rnd_next = {out_cells[6:0], rnd_fb};
  wire [7:0] cnt_next = out_cells + 8'h01;
  wire [7:0] out_next = run_sig_cnt ? cnt_next : rnd_next;

  // ------------------------------------------------------------
  // tap next-state decode
  // ------------------------------------------------------------
  always_comb begin
    case (state_q)
      ST_RESET: state_d = pin.tms ? ST_RESET : ST_IDLE;
      ST_IDLE: state_d = pin.tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: state_d = pin.tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: state_d = pin.tms ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR: state_d = pin.tms ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: state_d = pin.tms ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: state_d = pin.tms ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: state_d = pin.tms ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: state_d = pin.tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: state_d = pin.tms ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: state_d = pin.tms ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR: state_d = pin.tms ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: state_d = pin.tms ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: state_d = pin.tms ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: state_d = pin.tms ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: state_d = pin.tms ? ST_SEL_DR : ST_IDLE;
      default: state_d = ST_RESET;
    endcase
  end

  // ------------------------------------------------------------
  // tap controller, advanced on the rising tck edge
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_RESET;
    end else if (!ctrl_en_q) begin
      // port disabled by software: hold in reset state
      state_q <= ST_RESET;
    end else if (pin.tck_rise) begin
      state_q <= state_d;
    end
  end

  // ------------------------------------------------------------
  // instruction path
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ir_sh_q <= IR_CAPTURE;
      ir_act_q <= IR_BYPASS;
    end else if (state_q == ST_RESET) begin
      // back to normal latch operation
      ir_sh_q <= IR_CAPTURE;
      ir_act_q <= IR_BYPASS;
    end else if (pin.tck_rise && state_q == ST_CAP_IR) begin
      ir_sh_q <= IR_CAPTURE;
    end else if (pin.tck_rise && state_q == ST_SH_IR) begin
      // one bit per edge, last bit moves on leaving into exit1
      ir_sh_q <= {pin.tdi, ir_sh_q[IR_W-1:1]};
    end else if (pin.tck_fall && state_q == ST_UPD_IR) begin
      // unknown codes are left in place and decode to bypass
      ir_act_q <= ir_sh_q;
    end
  end

  // ------------------------------------------------------------
  // bypass stage and control register
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bypass_q <= 1'b0;
      bcr_sh_q <= '0;
      bcr_q <= '0;
    end else if (pin.tck_rise) begin
      if (state_q == ST_CAP_DR) begin
        // control register keeps its value in capture
        bypass_q <= 1'b0;
      end else if (state_q == ST_SH_DR) begin
        bypass_q <= pin.tdi;
        if (sel_bcr) begin
          bcr_sh_q <= {pin.tdi, bcr_sh_q[BCR_W-1:1]};
        end
      end
    end else if (pin.tck_fall && state_q == ST_UPD_DR && sel_bcr) begin
      bcr_q <= bcr_sh_q;
    end
  end

  // ------------------------------------------------------------
  // boundary chain shift stages
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chain_q <= '0;
    end else if (pin.tck_rise) begin
      if (run_any) begin
        // inputs compress while outputs step, in the same edge
        chain_q <= {out_next, sig_next};
      end else if (state_q == ST_CAP_DR && sel_chain) begin
        chain_q <= {core_q, pin.data};
      end else if (state_q == ST_SH_DR && sel_chain) begin
        // seed loading path for the run-test operations
        chain_q <= {pin.tdi, chain_q[CHAIN_W-1:1]};
      end
    end
  end

  // ------------------------------------------------------------
  // shadow latches, all on the falling tck edge
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shadow_q <= '0;
    end else if (pin.tck_fall) begin
      if (test_mode && state_q == ST_IDLE && (opcode == OP_SIG_RANDOM || opcode == OP_SIG_COUNT)) begin
        shadow_q <= chain_q;
      end else if (state_q == ST_UPD_DR && sel_chain) begin
        shadow_q <= chain_q;
      end
    end
  end

  // ------------------------------------------------------------
  // core latch, fed from input shadows in test mode
  // ------------------------------------------------------------
  wire [7:0] core_src = test_mode ? shadow_q[7:0] : pin.data;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_q <= '0;
    end else if (pin.le) begin
      core_q <= core_src; // transparent while enabled
    end
  end

  // ------------------------------------------------------------
  // output pins
  // ------------------------------------------------------------
  // the shadow is loaded on the same fall, so take the chain value
  // directly to avoid a one-cycle lag behind the latch
  wire fall_step = pin.tck_fall && run_any;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dout_q <= '0;
      dout_oe_q <= 1'b0;
    end else if (test_mode) begin
      dout_oe_q <= 1'b1;
      if (fall_step) begin
        dout_q <= chain_q[15:8];
      end else if (pin.tck_fall) begin
        dout_q <= shadow_q[15:8];
      end
    end else begin
      // normal mode: plain latch behaviour
      dout_q <= core_q;
      dout_oe_q <= ~pin.oe_n;
    end
  end

  // ------------------------------------------------------------
  // tdo, driven on the falling tck edge only
  // ------------------------------------------------------------
  wire dr_out = sel_bcr ? bcr_sh_q[0] : (sel_chain ? chain_q[0] : bypass_q);
  wire shifting = (state_q == ST_SH_IR) || (state_q == ST_SH_DR);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tdo_q <= 1'b0;
      tdo_oe_q <= 1'b0;
    end else if (pin.tck_fall) begin
      // exit1 and every other state release the pin
      tdo_oe_q <= shifting;
      if (state_q == ST_SH_IR) begin
        tdo_q <= ir_sh_q[0];
      end else if (state_q == ST_SH_DR) begin
        tdo_q <= dr_out;
      end
    end
  end

  // ------------------------------------------------------------
  // apb slave, one wait state per access
  // ------------------------------------------------------------
  wire acc = psel && penable;
  wire hit_ctrl = (paddr == ADDR_CTRL);
  wire hit_status = (paddr == ADDR_STATUS);
  wire hit_sign = (paddr == ADDR_SIGN);
  wire hit_any = hit_ctrl || hit_status || hit_sign;
  wire done = acc && pready_q; // the edge at which the transfer ends

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_ctrl) begin
      rd_mux[0] = ctrl_en_q;
    end else if (hit_status) begin
      rd_mux[ST_STATE_LSB +: 4] = state_q;
      rd_mux[ST_INSTR_LSB +: 8] = ir_act_q;
      rd_mux[ST_TEST_BIT] = test_mode;
    end else if (hit_sign) begin
      rd_mux[SG_IN_LSB +: 8] = chain_q[7:0];
      rd_mux[SG_OUT_LSB +: 8] = chain_q[15:8];
      rd_mux[SG_BCR_LSB +: BCR_W] = bcr_q;
    end
  end

  // answer prepared during the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (acc && !pready_q) begin
      pready_q <= 1'b1;
      prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr_q <= ~hit_any;
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // control register write, only at the completing edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_en_q <= CTRL_RESET;
    end else if (done && pwrite && hit_ctrl) begin
      ctrl_en_q <= pwdata[0];
    end
  end

  // ------------------------------------------------------------
  // port drive
  // ------------------------------------------------------------
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign tdo = tdo_q;
  assign tdo_oe = tdo_oe_q;
  assign data_out = dout_q;
  assign data_out_oe = dout_oe_q;

endmodule : scan_signature_pattern_tap
`default_nettype wire

// *** dv/scan_tap_monitor.sv ***
`timescale 1ns/10ps
`default_nettype none
module scan_tap_monitor (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave side
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  // tap pins
  input wire logic tck,
  input wire logic tdo,
  input wire logic tdo_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // pclk cycles since tck fell, saturating
  // ----------------------------------------
  logic tck_q; // tck seen one cycle ago
  logic [3:0] fall_age_q; // saturates so a stopped tck never wraps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tck_q <= 1'b0;
      fall_age_q <= 4'hF;
    end else begin
      tck_q <= tck;
      fall_age_q <= (tck_q && !tck) ? 4'h0 : (fall_age_q == 4'hF) ? 4'hF : fall_age_q + 4'h1;
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  // tdo pins move about two cycles after a fall; a rise is seen later still, so four separates the edges
  property p_tdo_on_fall; $changed(tdo) |-> fall_age_q <= 4'h4; endproperty
  property p_oe_on; $rose(tdo_oe) |-> fall_age_q <= 4'h4; endproperty
  property p_oe_off; $fell(tdo_oe) |-> fall_age_q <= 4'h4; endproperty
  property p_ready_pulse; pready |=> !pready; endproperty
  property p_ready_phase; pready |-> psel && penable; endproperty
  property p_apb_wait; (psel && !penable) ##1 (psel && penable) |-> !pready ##1 pready; endproperty
  property p_err_ready; pslverr |-> pready; endproperty
  property p_err_data; pslverr |-> prdata == 32'h0; endproperty
  a_tdo_on_fall: assert property (p_tdo_on_fall) else $error("tdo moved away from a tck fall");
  a_oe_on: assert property (p_oe_on) else $error("tdo driver enabled away from a tck fall");
  a_oe_off: assert property (p_oe_off) else $error("tdo driver released away from a tck fall");
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
  a_ready_phase: assert property (p_ready_phase) else $error("pready outside access phase");
  a_apb_wait: assert property (p_apb_wait) else $error("apb answer not in second access cycle");
  a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
  a_err_data: assert property (p_err_data) else $error("refused read returned data");
  c_oe_on: cover property ($rose(tdo_oe));
  c_oe_off: cover property ($fell(tdo_oe));
  c_err: cover property (pslverr);
endmodule : scan_tap_monitor
`default_nettype wire

// *** dv/tap_ctrl_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module tap_ctrl_model (
  // bench clock
  input wire logic pclk,
  // tap drive
  output logic tck,
  output logic tms,
  output logic tdi,
  // tap answer
  input wire logic tdo,
  input wire logic tdo_oe
);
  // tck idles low and stands still between steps
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // one tck period of eight pclk: tms and tdi move after the fall, tdo taken just before the rise
  task automatic step(input logic m, input logic i, output logic o, output logic oe);
    @(posedge pclk);
    tms <= m;
    tdi <= i;
    repeat (3) @(posedge pclk);
    // a released tdo has no pull, so it reads as the inverse of the stale level
    o = tdo_oe ? tdo : ~tdo;
    oe = tdo_oe;
    tck <= 1'b1;
    repeat (4) @(posedge pclk);
    tck <= 1'b0;
  endtask : step
  // outside shift states tdi carries no meaning, so it keeps toggling
  task automatic move(input logic m);
    logic o;
    logic oe;
    step(m, ~tdi, o, oe);
  endtask : move
  // from idle: full ir or dr scan, lsb first, back to idle
  task automatic scan(input logic ir, input int n, input logic [15:0] din,
                      output logic [15:0] dout, output logic oe_sh, output logic oe_ex);
    logic o;
    logic oe;
    dout = 16'h0000;
    oe_sh = 1'b1;
    move(1'b1);
    if (ir) begin
      move(1'b1);
    end
    move(1'b0);
    move(1'b0);
    for (int k = 0; k < n; k++) begin
      step(k == n - 1, din[k], o, oe);
      dout[k] = o;
      oe_sh = oe_sh & oe;
    end
    step(1'b1, ~tdi, o, oe_ex);
    move(1'b0);
  endtask : scan
  // five ones reach test-logic-reset from any state
  task automatic to_reset();
    repeat (5) move(1'b1);
  endtask : to_reset
endmodule : tap_ctrl_model
`default_nettype wire

// *** dv/scan_signature_pattern_tap_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module scan_signature_pattern_tap_tb;
  import scan_tap_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic tck, tms, tdi, tdo, tdo_oe, latch_enable, output_enable_n, data_out_oe, e, a, b;
  logic [7:0] data_in, data_out;
  logic [15:0] d;
  int num_errors, n_compared;
  scan_signature_pattern_tap u_scan_signature_pattern_tap (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .data_in(data_in),
    .latch_enable(latch_enable), .output_enable_n(output_enable_n), .data_out(data_out),
    .data_out_oe(data_out_oe));
  tap_ctrl_model u_tap_ctrl_model (.pclk(pclk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict
  // apb transfer; request held until pready is seen high, only the watchdog ends a wait
  task automatic apb(input logic [11:0] ad, input logic w, input logic [31:0] wd);
    @(posedge pclk);
    paddr <= ad;
    pwrite <= w;
    pwdata <= wd;
    psel <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // load control and seed, enter run test, step in idle against a local model
  task automatic run_op(input logic [2:0] op, input logic [7:0] mask, input logic [15:0] seed);
    logic [7:0] si, so, dv;
    logic o, oe;
    u_tap_ctrl_model.scan(1'b1, 8, IR_BCR_SCAN, d, a, b);
    u_tap_ctrl_model.scan(1'b0, 11, {5'h00, mask, op}, d, a, b);
    u_tap_ctrl_model.scan(1'b1, 8, IR_CHAIN_SCAN, d, a, b);
    u_tap_ctrl_model.scan(1'b0, 16, seed, d, a, b);
    u_tap_ctrl_model.scan(1'b1, 8, IR_RUN_TEST, d, a, b);
    si = seed[7:0];
    so = seed[15:8];
    for (int k = 0; k < 10; k++) begin
      dv = 8'(k * 37 + 5);
      data_in <= dv;
      repeat (4) @(posedge pclk);
      chk(data_out, so);
      chk(data_out_oe, 1'b1);
      u_tap_ctrl_model.step(1'b0, k[0], o, oe);
      si = {si[6:0], ^(si & LFSR_TAPS)} ^ (dv & ~mask);
      so = (op == OP_SIG_COUNT) ? so + 8'h01 : {so[6:0], ^(so & LFSR_TAPS)};
    end
    repeat (4) @(posedge pclk);
    chk(data_out, so);
    apb(ADDR_SIGN, 1'b0, 32'h0);
    chk(r[7:0], si);
    chk(r[15:8], so);
    chk(r[26:16], {mask, op});
    $display("run test op %h done", op);
  endtask : run_op
  // ----------------------------------------
  // clock, watchdog, sequence
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // the whole run needs a few hundred tck steps of eight pclk, far below this span
  initial begin
    #800us;
    num_errors++;
    give_verdict();
  end
  initial begin
    num_errors = 0;
    n_compared = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    data_in = 8'h5A;
    latch_enable = 1'b1;
    output_enable_n = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(ADDR_CTRL, 1'b0, 32'h0);
    chk(r, 32'h1);
    apb(12'hFFC, 1'b0, 32'h0);
    chk(e, 1'b1);
    chk(r, 32'h0);
    apb(ADDR_STATUS, 1'b1, 32'hFFFF_FFFF);
    chk(e, 1'b0);
    chk(data_out, 8'h5A);
    chk(data_out_oe, 1'b1);
    latch_enable <= 1'b0;
    data_in <= 8'hC3;
    repeat (8) @(posedge pclk);
    chk(data_out, 8'h5A);
    apb(ADDR_CTRL, 1'b1, 32'h0);
    u_tap_ctrl_model.move(1'b0);
    apb(ADDR_STATUS, 1'b0, 32'h0);
    chk(r[3:0], ST_RESET);
    apb(ADDR_CTRL, 1'b1, 32'h1);
    $display("register and latch test done");
    u_tap_ctrl_model.move(1'b0);
    u_tap_ctrl_model.scan(1'b1, 8, 16'h00FF, d, a, b);
    chk(d[7:0], IR_CAPTURE);
    chk(a, 1'b1);
    chk(b, 1'b0);
    apb(ADDR_STATUS, 1'b0, 32'h0);
    chk(r[15:8], IR_BYPASS);
    chk(r[3:0], ST_IDLE);
    u_tap_ctrl_model.scan(1'b0, 3, 16'h0005, d, a, b);
    chk(d[2:0], 3'b010);
    $display("ir and bypass scan test done");
    run_op(OP_SIG_RANDOM, 8'h21, 16'hA55A);
    run_op(OP_SIG_COUNT, 8'hF0, 16'hFE03);
    u_tap_ctrl_model.to_reset();
    apb(ADDR_STATUS, 1'b0, 32'h0);
    chk(r[16:0], {1'b0, IR_BYPASS, 4'h0, 4'(ST_RESET)});
    $display("return to reset test done");
    give_verdict();
  end
endmodule : scan_signature_pattern_tap_tb
bind scan_signature_pattern_tap scan_tap_monitor u_scan_tap_monitor (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .prdata(prdata), .tck(tck),
  .tdo(tdo), .tdo_oe(tdo_oe));
`default_nettype wire
